// >>> inc/tcp_pkg.sv
/*
   constants and carrier types for the timer capture/compare/pwm block.
   assumes a 32-bit classic wishbone register bus, word-aligned offsets.
*/
`default_nettype none
package tcp_pkg;
   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_COUNT = 8'h04;
   localparam logic [7:0] OFF_LIMIT = 8'h08;
   localparam logic [7:0] OFF_C0CTL = 8'h0C;
   localparam logic [7:0] OFF_C0VAL = 8'h10;
   localparam logic [7:0] OFF_C1CTL = 8'h14;
   localparam logic [7:0] OFF_C1VAL = 8'h18;
   // ----------------------------------------
   // timer and channel control fields, reset values, prescaler width
   // ----------------------------------------
   localparam int CTRL_FLAG = 7;
   localparam int CTRL_IE = 6;
   localparam int CTRL_HALT = 5;
   localparam int CTRL_CLR = 4;
   localparam int CHAN_FLAG = 7;
   localparam logic [2:0] RATE_EXT = 3'h7;
   localparam logic [2:0] RATE_RESET = 3'h0;
   localparam logic HALT_RESET = 1'b1;
   localparam logic [15:0] LIMIT_RESET = 16'hFFFF;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] VAL_RESET = 16'h0000;
   localparam int PRESC_W = 6;
   // ----------------------------------------
   // channel encodings
   // ----------------------------------------
   localparam logic [1:0] MODE_CAPT = 2'h0;
   localparam logic [1:0] MODE_UNBUF = 2'h1;
   localparam logic [1:0] MODE_BUF = 2'h2;
   localparam logic [1:0] ELS_OFF = 2'h0;
   localparam logic [1:0] ELS_TOGGLE = 2'h1;
   localparam logic [1:0] ELS_CLEAR = 2'h2;
   localparam logic [1:0] ELS_SET = 2'h3;
   typedef struct packed {
      logic flag;
      logic irq_en;
      logic [1:0] mode;
      logic [1:0] els;
      logic tov;
      logic full;
   } tcp_chan_ctl_t;
   localparam tcp_chan_ctl_t CHAN_CTL_RESET = 8'h00;
endpackage
`default_nettype wire

// >>> core/tcp_timer.sv
/*
   one 16-bit timer: prescaler, counter with period limit, two channels
   of input capture, output compare and pwm, channel pairing.
   assumes a classic wishbone master and pins synchronous to clk_i.
*/
// Chosen here: register access over Wishbone and the address map.
`timescale 1ns/1ps
`default_nettype none
module tcp_timer #(
   parameter bit SECOND_TIMER = 1'b1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [1:0] chan_pin_i,
   output logic [1:0] chan_pin_o,
   output logic [1:0] chan_pin_oe_o,
   input wire logic ext_count_clock_pin_i,
   output logic irq_o
);
   // ----------------------------------------
   // bus slave
   // ----------------------------------------
   logic ack_reg;
   logic [31:0] dat_reg;
   logic req_new;
   logic wr;
   logic [31:0] rd_next;
   logic wr_ctrl;
   logic wr_limit;
   logic [1:0] wr_ctl;
   logic [1:0] wr_val;
   logic rd_ctrl;
   logic [1:0] rd_ctl;

   logic wrap_flag_reg;
   logic wrap_arm_reg;
   logic wrap_ie_reg;
   logic halt_reg;
   logic [2:0] rate_reg;
   logic [15:0] limit_reg;
   logic [15:0] cnt_reg;
   logic [15:0] cnt_next;
   localparam int PW = tcp_pkg::PRESC_W;
   logic [PW-1:0] presc_reg;
   logic [PW-1:0] presc_mask;
   logic ext_prev_reg;
   logic tick;
   logic clr_req;
   logic count_tick;
   logic wrap_evt;
   logic linked;
   logic act_sel_reg;
   logic last_wr_reg;
   logic irq_reg;
   tcp_pkg::tcp_chan_ctl_t ctl_all [2];
   logic [15:0] val_all [2];
   logic [1:0] capt_vec;
   logic [1:0] match_vec;
   logic [1:0] pin_vec;

   assign req_new = wb_cyc_i & wb_stb_i & ~ack_reg;
   assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;
   assign wr_ctrl = wr & wb_sel_i[0] & (wb_adr_i == tcp_pkg::OFF_CTRL);
   assign wr_limit = wr & (wb_adr_i == tcp_pkg::OFF_LIMIT);
   assign wr_ctl[0] = wr & wb_sel_i[0] & (wb_adr_i == tcp_pkg::OFF_C0CTL);
   assign wr_ctl[1] = wr & wb_sel_i[0] & (wb_adr_i == tcp_pkg::OFF_C1CTL);
   assign wr_val[0] = wr & (wb_adr_i == tcp_pkg::OFF_C0VAL);
   assign wr_val[1] = wr & (wb_adr_i == tcp_pkg::OFF_C1VAL);
   assign rd_ctrl = req_new & ~wb_we_i & (wb_adr_i == tcp_pkg::OFF_CTRL);
   assign rd_ctl[0] = req_new & ~wb_we_i & (wb_adr_i == tcp_pkg::OFF_C0CTL);
   assign rd_ctl[1] = req_new & ~wb_we_i & (wb_adr_i == tcp_pkg::OFF_C1CTL);

   always_comb
   begin
      rd_next = 32'h00000000;
      case (wb_adr_i)
         tcp_pkg::OFF_CTRL:
            rd_next = {24'h000000, wrap_flag_reg, wrap_ie_reg, halt_reg,
                       2'h0, rate_reg};
         tcp_pkg::OFF_COUNT: rd_next = {16'h0000, cnt_reg};
         tcp_pkg::OFF_LIMIT: rd_next = {16'h0000, limit_reg};
         tcp_pkg::OFF_C0CTL: rd_next = {24'h000000, ctl_all[0]};
         tcp_pkg::OFF_C0VAL: rd_next = {16'h0000, val_all[0]};
         tcp_pkg::OFF_C1CTL: rd_next = {24'h000000, ctl_all[1]};
         tcp_pkg::OFF_C1VAL: rd_next = {16'h0000, val_all[1]};
         default: rd_next = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h00000000;
      end
      else
      begin
         ack_reg <= req_new;
         if (req_new)
            dat_reg <= wb_we_i ? 32'h00000000 : rd_next;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;

   // ----------------------------------------
   // timer control register
   // ----------------------------------------
   assign clr_req = wr_ctrl & wb_dat_i[tcp_pkg::CTRL_CLR];

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wrap_ie_reg <= 1'b0;
         halt_reg <= tcp_pkg::HALT_RESET;
         rate_reg <= tcp_pkg::RATE_RESET;
      end
      else if (wr_ctrl)
      begin
         wrap_ie_reg <= wb_dat_i[tcp_pkg::CTRL_IE];
         halt_reg <= wb_dat_i[tcp_pkg::CTRL_HALT];
         rate_reg <= wb_dat_i[2:0];
      end
   end

   // wrap flag: read while set, then write 0; a new wrap wins
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wrap_flag_reg <= 1'b0;
         wrap_arm_reg <= 1'b0;
      end
      else
      begin
         if (wrap_evt)
            wrap_flag_reg <= 1'b1;
         else if (wr_ctrl && !wb_dat_i[tcp_pkg::CTRL_FLAG] && wrap_arm_reg)
            wrap_flag_reg <= 1'b0;
         if (wrap_evt || wr_ctrl)
            wrap_arm_reg <= 1'b0;
         else if (rd_ctrl && wrap_flag_reg)
            wrap_arm_reg <= 1'b1;
      end
   end

   // ----------------------------------------
   // prescaler and counter
   // ----------------------------------------
   assign presc_mask = PW'((7'h01 << rate_reg) - 7'h01);

   always_comb
   begin
      if (rate_reg == tcp_pkg::RATE_EXT)
         tick = SECOND_TIMER & ext_count_clock_pin_i & ~ext_prev_reg;
      else
         tick = (presc_reg & presc_mask) == presc_mask;
   end

   assign count_tick = tick & ~halt_reg & ~clr_req;
   assign wrap_evt = count_tick & (cnt_reg == limit_reg);
   assign cnt_next = wrap_evt ? tcp_pkg::COUNT_RESET : cnt_reg + 16'h0001;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ext_prev_reg <= 1'b0;
      else
         ext_prev_reg <= ext_count_clock_pin_i;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i || clr_req)
         presc_reg <= '0;
      else if (!halt_reg)
         presc_reg <= presc_reg + PW'(1);
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i || clr_req)
         cnt_reg <= tcp_pkg::COUNT_RESET;
      else if (count_tick)
         cnt_reg <= cnt_next;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         limit_reg <= tcp_pkg::LIMIT_RESET;
      else if (wr_limit)
      begin
         if (wb_sel_i[0])
            limit_reg[7:0] <= wb_dat_i[7:0];
         if (wb_sel_i[1])
            limit_reg[15:8] <= wb_dat_i[15:8];
      end
   end

   // ----------------------------------------
   // channel pairing
   // ----------------------------------------
   assign linked = ctl_all[0].mode[1];

   always_ff @(posedge clk_i)
   begin
      if (rst_i || !linked)
      begin
         act_sel_reg <= 1'b0;
         last_wr_reg <= 1'b0;
      end
      else
      begin
         if (wr_val[1])
            last_wr_reg <= 1'b1;
         else if (wr_val[0])
            last_wr_reg <= 1'b0;
         if (wrap_evt)
            act_sel_reg <= last_wr_reg;
      end
   end

   // ----------------------------------------
   // channels
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_chan
         tcp_pkg::tcp_chan_ctl_t ctl_reg;
         logic [15:0] val_reg;
         logic [15:0] val_use;
         logic arm_reg;
         logic prev_reg;
         logic pin_reg;
         logic pin_next;
         logic oe_reg;
         logic active;
         logic capt_mode;
         logic cmp_mode;
         logic capt_evt;
         logic match_evt;

         assign active = (gi == 0) || !linked;
         assign capt_mode = (ctl_reg.mode == tcp_pkg::MODE_CAPT) &&
                            (ctl_reg.els != tcp_pkg::ELS_OFF);
         assign cmp_mode = ctl_reg.mode != tcp_pkg::MODE_CAPT;
         assign capt_evt = active & capt_mode &
            ((ctl_reg.els[0] & chan_pin_i[gi] & ~prev_reg) |
             (ctl_reg.els[1] & ~chan_pin_i[gi] & prev_reg));
         assign val_use = (gi == 0 && linked && act_sel_reg) ?
                          val_all[1] : val_reg;
         assign match_evt = active & cmp_mode & count_tick &
                            (cnt_next == val_use);

         always_comb
         begin
            pin_next = pin_reg;
            if (wrap_evt && ctl_reg.tov)
               pin_next = ~pin_reg;
            if (match_evt)
            begin
               case (ctl_reg.els)
                  tcp_pkg::ELS_TOGGLE: pin_next = ~pin_next;
                  tcp_pkg::ELS_CLEAR: pin_next = 1'b0;
                  tcp_pkg::ELS_SET: pin_next = 1'b1;
                  default: pin_next = pin_next;
               endcase
            end
            if (ctl_reg.full && ctl_reg.tov)
               pin_next = 1'b1;
         end

         always_ff @(posedge clk_i)
         begin
            if (rst_i)
            begin
               pin_reg <= 1'b0;
               oe_reg <= 1'b0;
               prev_reg <= 1'b0;
            end
            else
            begin
               pin_reg <= pin_next;
               oe_reg <= active & cmp_mode &
                         (ctl_reg.els != tcp_pkg::ELS_OFF);
               prev_reg <= chan_pin_i[gi];
            end
         end

         always_ff @(posedge clk_i)
         begin
            if (rst_i)
               ctl_reg <= tcp_pkg::CHAN_CTL_RESET;
            else
            begin
               if (wr_ctl[gi])
                  ctl_reg[6:0] <= wb_dat_i[6:0];
               if (capt_evt || match_evt)
                  ctl_reg.flag <= 1'b1;
               else if (wr_ctl[gi] && !wb_dat_i[tcp_pkg::CHAN_FLAG] &&
                        arm_reg)
                  ctl_reg.flag <= 1'b0;
            end
         end

         always_ff @(posedge clk_i)
         begin
            if (rst_i || capt_evt || match_evt || wr_ctl[gi])
               arm_reg <= 1'b0;
            else if (rd_ctl[gi] && ctl_reg.flag)
               arm_reg <= 1'b1;
         end

         always_ff @(posedge clk_i)
         begin
            if (rst_i)
               val_reg <= tcp_pkg::VAL_RESET;
            else if (capt_evt)
               val_reg <= cnt_reg;
            else if (wr_val[gi])
            begin
               if (wb_sel_i[0])
                  val_reg[7:0] <= wb_dat_i[7:0];
               if (wb_sel_i[1])
                  val_reg[15:8] <= wb_dat_i[15:8];
            end
         end

         assign ctl_all[gi] = ctl_reg;
         assign val_all[gi] = val_reg;
         assign capt_vec[gi] = capt_evt;
         assign match_vec[gi] = match_evt;
         assign pin_vec[gi] = pin_reg;
         assign chan_pin_o[gi] = pin_reg;
         assign chan_pin_oe_o[gi] = oe_reg;
      end
   endgenerate

   // ----------------------------------------
   // interrupt request
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         irq_reg <= 1'b0;
      else
         irq_reg <= (wrap_flag_reg & wrap_ie_reg) |
            (ctl_all[0].flag & ctl_all[0].irq_en) |
            (ctl_all[1].flag & ctl_all[1].irq_en & ~linked);
   end

   assign irq_o = irq_reg;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_wrap_linked;
      linked && wrap_evt;
   endsequence

   sequence s_set_match;
      match_vec[0] && ctl_all[0].els == tcp_pkg::ELS_SET &&
      !(ctl_all[0].full && ctl_all[0].tov) && !wr_ctl[0];
   endsequence

   a_wrap_flag_set:
   assert property (wrap_evt |=> wrap_flag_reg && cnt_reg == 16'h0000)
      else $error("wrap did not set flag and zero counter");

   a_counter_span:
   assert property (count_tick && !wrap_evt |=>
                    cnt_reg == $past(cnt_reg) + 16'h0001)
      else $error("counter did not step by one");

   a_clear_counter:
   assert property (clr_req |=> cnt_reg == 16'h0000 && presc_reg == '0)
      else $error("counter reset bit did not clear");

   a_rate_div_two:
   assert property (count_tick && rate_reg == 3'h1 && !wr_ctrl |=> !tick)
      else $error("divide by two ticked twice in a row");

   a_link_switch:
   assert property (s_wrap_linked |=> act_sel_reg == $past(last_wr_reg))
      else $error("wrong channel took control at wrap");

   a_capture_value:
   assert property (capt_vec[0] |=>
                    val_all[0] == $past(cnt_reg) && ctl_all[0].flag)
      else $error("capture did not store the counter");

   a_match_set:
   assert property (s_set_match |=> pin_vec[0] && chan_pin_o[0])
      else $error("set on match did not drive pin high");

   a_full_duty:
   assert property (ctl_all[0].full && ctl_all[0].tov |=> chan_pin_o[0])
      else $error("full duty did not hold pin high");

   a_link_pin_free:
   assert property (linked && $past(linked) |-> !chan_pin_oe_o[1] && !match_vec[1])
      else $error("paired channel one still active");

   a_irq_gate:
   assert property (wrap_flag_reg && wrap_ie_reg |=> irq_o)
      else $error("enabled wrap flag did not raise interrupt");

   a_first_no_pin:
   assert property (!SECOND_TIMER && rate_reg == tcp_pkg::RATE_EXT |-> !tick)
      else $error("first timer counted from the pin");

endmodule // tcp_timer
`default_nettype wire

// >>> verif/tcp_pin_model.sv
/*
   partner model: event sources and loads on the channel pins, and the
   external count clock. assumes pins synchronous to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module tcp_pin_model (
   input wire logic clk_i,
   input wire logic [1:0] pin_o_i,
   input wire logic [1:0] pin_oe_i,
   input wire logic [1:0] ev_i,
   input wire logic ext_run_i,
   output logic [1:0] pin_i_o,
   output logic ext_clk_o
);
   // ----------------------------------------
   // pin level: the driving party wins
   // ----------------------------------------
   assign pin_i_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ev_i);
   // ----------------------------------------
   // count clock at bus/4, still outside bursts
   // ----------------------------------------
   logic [1:0] ph_reg = 2'h0;
   always_ff @(posedge clk_i)
   begin
      ph_reg <= ext_run_i ? ph_reg + 2'h1 : 2'h0;
   end
   assign ext_clk_o = ph_reg[1];
endmodule // tcp_pin_model
`default_nettype wire

// >>> verif/tcp_timer_tb.sv
/*
   self-checking bench for tcp_timer over wishbone and channel pins.
   assumes tcp_pkg and tcp_pin_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tcp_timer_tb;
   localparam logic [7:0] A_CTL = tcp_pkg::OFF_CTRL;
   localparam logic [7:0] A_CNT = tcp_pkg::OFF_COUNT;
   localparam logic [7:0] A_LIM = tcp_pkg::OFF_LIMIT;
   localparam logic [7:0] A_C0C = tcp_pkg::OFF_C0CTL;
   localparam logic [7:0] A_C0V = tcp_pkg::OFF_C0VAL;
   localparam logic [7:0] A_C1C = tcp_pkg::OFF_C1CTL;
   localparam logic [7:0] A_C1V = tcp_pkg::OFF_C1VAL;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic ack;
   logic [1:0] pin_i;
   logic [1:0] pin_o;
   logic [1:0] pin_oe;
   logic [1:0] ev = 2'h0;
   logic ext_run = 1'b0;
   logic ext_clk;
   logic irq;
   logic [31:0] v;
   int fails = 0;
   int checks_done = 0;
   int hi;
   int per;
   always #5 clk_i = ~clk_i;
   tcp_timer #(.SECOND_TIMER(1'b1)) DUT (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .chan_pin_i(pin_i), .chan_pin_o(pin_o), .chan_pin_oe_o(pin_oe),
      .ext_count_clock_pin_i(ext_clk), .irq_o(irq));
   tcp_pin_model pm (.clk_i(clk_i), .pin_o_i(pin_o), .pin_oe_i(pin_oe),
      .ev_i(ev), .ext_run_i(ext_run), .pin_i_o(pin_i),
      .ext_clk_o(ext_clk));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] s, e);
      checks_done++;
      if (s !== e)
      begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int k;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      k = 0;
      do
      begin
         @(posedge clk_i);
         k++;
      end
      while (ack !== 1'b1 && k < 16);
      v = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (ack !== 1'b1)
      begin
         fails++;
         stop_test();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a);
      bus(1'b0, a, 32'h0);
   endtask
   task automatic ticks(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic wait_pin(input logic l);
      int k;
      k = 0;
      while (pin_o[0] !== l && k < 2000)
      begin
         @(posedge clk_i);
         k++;
      end
      if (k >= 2000)
      begin
         fails++;
         stop_test();
      end
   endtask
   task automatic pulse();
      wait_pin(1'b0);
      wait_pin(1'b1);
      hi = 0;
      while (pin_o[0] === 1'b1 && hi < 2000)
      begin
         @(posedge clk_i);
         hi++;
      end
      per = hi;
      while (pin_o[0] === 1'b0 && per < 2000)
      begin
         @(posedge clk_i);
         per++;
      end
      if (hi >= 2000 || per >= 2000)
      begin
         fails++;
         stop_test();
      end
   endtask
   task automatic ones(output int o);
      o = 0;
      repeat (16)
      begin
         @(posedge clk_i);
         o += (pin_o[0] === 1'b1);
      end
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset();
      rd(A_CTL);
      check("ctrl", v, 32'h20);
      rd(A_LIM);
      check("limit", v, 32'(tcp_pkg::LIMIT_RESET));
      rd(A_CNT);
      check("count", v, 32'(tcp_pkg::COUNT_RESET));
      rd(8'h40);
      check("unmapped", v, 32'h0);
      check("pins", {28'h0, pin_oe, pin_o}, 32'h0);
      $display("test reset done");
   endtask
   task automatic t_rate();
      for (int k = 0; k < 7; k++)
      begin
         wr(A_CTL, 32'h30);
         rd(A_CNT);
         check("cleared", v, 32'h0);
         wr(A_CTL, 32'(k));
         ticks(254);
         wr(A_CTL, 32'h20 | 32'(k));
         rd(A_CNT);
         check("rate", 32'((v + 32'd1 - (32'd256 >> k)) <= 32'd2), 1);
      end
      $display("test rate done");
   endtask
   task automatic t_wrap();
      wr(A_CTL, 32'h30);
      wr(A_LIM, 32'h3);
      wr(A_CTL, 32'h0);
      ticks(8);
      check("irq gated", irq, 1'b0);
      rd(A_CNT);
      check("span", 32'(v <= 32'h3), 1);
      rd(A_CTL);
      check("wrap flag", v[7], 1'b1);
      wr(A_CTL, 32'hC0);
      ticks(2);
      check("irq on", irq, 1'b1);
      wr(A_CTL, 32'h60);
      rd(A_CTL);
      wr(A_CTL, 32'h60);
      ticks(2);
      check("irq off", irq, 1'b0);
      $display("test wrap done");
   endtask
   task automatic t_capture();
      logic [31:0] c;
      wr(A_LIM, 32'hFFFF);
      wr(A_CTL, 32'h0);
      ticks(40);
      wr(A_CTL, 32'h20);
      rd(A_CNT);
      c = v;
      wr(A_C0C, 32'h44);
      wr(A_C1C, 32'h08);
      ev <= 2'b11;
      ticks(4);
      rd(A_C0V);
      check("capture", v, c);
      rd(A_C0C);
      check("cap flag", v[7], 1'b1);
      check("cap irq", irq, 1'b1);
      rd(A_C1V);
      check("no rise", v, 32'h0);
      ev <= 2'b00;
      ticks(4);
      rd(A_C1V);
      check("fall", v, c);
      rd(A_C0C);
      wr(A_C0C, 32'h44);
      ticks(2);
      check("cap irq off", irq, 1'b0);
      $display("test capture done");
   endtask
   task automatic t_match();
      int n;
      rd(A_CNT);
      wr(A_LIM, v + 32'd50);
      wr(A_C0V, v);
      wr(A_C0C, 32'h1C);
      ticks(2);
      check("drive", {pin_oe[0], pin_o[0]}, 2'b10);
      wr(A_CTL, 32'h0);
      n = 0;
      while (pin_o[0] !== 1'b1 && n < 400)
      begin
         @(posedge clk_i);
         n++;
      end
      check("passed", 32'(n > 40), 1);
      check("set", pin_o[0], 1'b1);
      rd(A_C0C);
      check("cmp flag", v[7], 1'b1);
      wr(A_C0C, 32'h18);
      wait_pin(1'b0);
      check("clear", pin_o[0], 1'b0);
      $display("test match done");
   endtask
   task automatic t_pwm();
      int o;
      wr(A_CTL, 32'h30);
      wr(A_LIM, 32'h7);
      wr(A_C0V, 32'h3);
      wr(A_C0C, 32'h1A);
      wr(A_CTL, 32'h0);
      pulse();
      check("width", hi, 3);
      check("period", per, 8);
      wr(A_C0C, 32'h1B);
      ticks(10);
      ones(o);
      check("full", o, 16);
      wr(A_C0C, 32'h18);
      ticks(16);
      ones(o);
      check("zero", o, 0);
      $display("test pwm done");
   endtask
   task automatic t_link();
      wr(A_CTL, 32'h30);
      wr(A_C0V, 32'h2);
      wr(A_C1C, 32'h1C);
      wr(A_C0C, 32'h2A);
      wr(A_CTL, 32'h0);
      pulse();
      check("first", hi, 2);
      check("pin1 free", pin_oe[1], 1'b0);
      wr(A_C1V, 32'h5);
      pulse();
      check("second", hi, 5);
      wr(A_C0V, 32'h1);
      pulse();
      check("third", hi, 1);
      check("link period", per, 8);
      $display("test link done");
   endtask
   task automatic t_ext();
      wr(A_C0C, 32'h0);
      wr(A_LIM, 32'hFFFF);
      wr(A_CTL, 32'h37);
      wr(A_CTL, 32'h07);
      ext_run <= 1'b1;
      ticks(40);
      ext_run <= 1'b0;
      ticks(4);
      rd(A_CNT);
      check("ext count", v, 32'd10);
      $display("test ext done");
   endtask
   initial
   begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_rate();
      t_wrap();
      t_capture();
      t_match();
      t_pwm();
      t_link();
      t_ext();
      stop_test();
   end
endmodule // tcp_timer_tb
`default_nettype wire
